/* core/uoes_pkg.sv */
// Purpose: Shared constants and carriers for the USB error, status and control block
// Assumes: 40 MHz single clock, plain register port with byte offsets
// Notes: Register offsets are local to this block
package uoes_pkg;

   // =========================================================
   // Register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int FIELD_W = 8;
   localparam logic [ADDR_W-1:0] OFS_ERR_FLAG = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ERR_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h14;

   // =========================================================
   // Field positions
   localparam int CTL_J_BIT = 7;
   localparam int CTL_SE0_BIT = 6;
   localparam int CTL_PKT_BIT = 5;
   localparam int CTL_RST_BIT = 4;
   localparam int CTL_HOST_BIT = 3;
   localparam int CTL_RESUME_BIT = 2;
   localparam int CTL_PPB_BIT = 1;
   localparam int CTL_EN_BIT = 0;
   localparam int IRQ_TRN_BIT = 3;
   localparam int IRQ_UERR_BIT = 1;
   localparam logic [FIELD_W-1:0] ERR_EN_RESET = 8'h00;
   localparam logic [1:0] STAT_PAD = 2'h0;

   // =========================================================
   // Timing
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int SOF_PERIOD_US = 1000;
   localparam int SOF_PERIOD_CYCLES = CLK_FREQ_KHZ * SOF_PERIOD_US / 1000;
   localparam int SOF_CNT_W = 16;
   localparam int STAT_FIFO_DEPTH = 4;

   // =========================================================
   // Carriers
   typedef struct packed {
      logic bit_stuff;
      logic bus_matrix;
      logic dma;
      logic turnaround;
      logic data_size;
      logic crc16;
      logic crc5_or_eof;
      logic pid_check;
   } uoes_err_t;

   typedef struct packed {
      logic [3:0] endpoint;
      logic tx;
      logic odd_bank;
   } uoes_rec_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } uoes_bus_t;

endpackage

/* core/uoes_stat_fifo.sv */
// Purpose: Small FIFO of completed-transfer status records
// Assumes: DEPTH is a power of two, pointers wrap naturally
// Notes: A push into a full FIFO is refused, push_ready shows it
`timescale 1ns/1ps

module uoes_stat_fifo
   import uoes_pkg::*;
#(
   parameter int DEPTH = STAT_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic push_valid,
   output logic push_ready,
   input uoes_rec_t push_rec,
   input wire logic pop,
   output logic head_valid,
   output uoes_rec_t head_rec
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

   typedef struct packed {
      uoes_rec_t [DEPTH-1:0] mem;
      logic [PW-1:0] rd_ptr;
      logic [PW-1:0] wr_ptr;
      logic [PW:0] count;
   } uoes_fifo_state_t;

   uoes_fifo_state_t s;
   uoes_fifo_state_t next_s;
   logic push_ok;
   logic pop_ok;

   assign push_ready = (s.count != FULL_COUNT);
   assign head_valid = (s.count != '0);
   assign head_rec = s.mem[s.rd_ptr];
   assign push_ok = push_valid && push_ready;
   assign pop_ok = pop && head_valid;

   // =========================================================
   // Next state
   always_comb begin
      next_s = s;
      if (push_ok) begin
         next_s.mem[s.wr_ptr] = push_rec;
         next_s.wr_ptr = s.wr_ptr + 1'b1;
      end
      if (pop_ok) begin
         next_s.rd_ptr = s.rd_ptr + 1'b1;
      end
      if (push_ok && !pop_ok) begin
         next_s.count = s.count + 1'b1;
      end else if (pop_ok && !push_ok) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule // uoes_stat_fifo

/* core/uoes_top.sv */
// Purpose: USB error enables, transfer status window and module control register
// Assumes: Error, setup and token-busy events come from logic on clk; line pins are async
// Notes: Registers reached over a plain port, read data one cycle after the strobe
`timescale 1ns/1ps

module uoes_top
   import uoes_pkg::*;
#(
   parameter logic [SOF_CNT_W-1:0] SOF_CYCLES = SOF_CNT_W'(SOF_PERIOD_CYCLES)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input uoes_err_t err_event,
   input wire logic eof_err_event,
   input wire logic rec_push,
   output logic rec_push_ready,
   input uoes_rec_t rec_in,
   input wire logic setup_token_rx,
   input wire logic token_in_progress,
   input wire logic live_j_state_pin,
   input wire logic live_se0_pin,
   output logic usb_main_irq_request,
   output logic packet_processing_disable,
   output logic bus_reset_drive,
   output logic host_capability_en,
   output logic host_ctl_reset,
   output logic resume_drive,
   output logic low_speed_eop,
   output logic pingpong_pointer_clear,
   output logic module_enable,
   output logic frame_start_token_en,
   output logic frame_start_tick
);

   typedef struct packed {
      logic [FIELD_W-1:0] err_flag;
      logic [FIELD_W-1:0] err_en;
      logic token_done_ie;
      logic usb_error_summary_en;
      logic pkt_dis;
      logic bus_rst;
      logic host_en;
      logic resume;
      logic ppb_rst;
      logic mod_en;
      logic j_s1;
      logic j_s2;
      logic se0_s1;
      logic se0_s2;
      logic host_rst_pulse;
      logic ls_eop_pulse;
      logic sof_tick;
      logic [SOF_CNT_W-1:0] sof_cnt;
      logic [DATA_W-1:0] rdata;
   } uoes_state_t;

   uoes_state_t s;
   uoes_state_t next_s;
   uoes_bus_t bus;
   uoes_rec_t head_rec;
   uoes_err_t err_set;
   logic head_valid;
   logic fifo_pop;
   logic err_summary;
   logic [FIELD_W-1:0] ctl_read;
   logic [FIELD_W-1:0] irq_read;
   logic [FIELD_W-1:0] stat_read;

   // =========================================================
   // Helpers
   function automatic logic [FIELD_W-1:0] w1c_update(
      input logic [FIELD_W-1:0] cur,
      input logic [FIELD_W-1:0] set,
      input logic [FIELD_W-1:0] clr
   );
      // Hardware set beats a same-cycle software clear
      return (cur & ~clr) | set;
   endfunction

   function automatic logic hit(
      input uoes_bus_t b,
      input logic [ADDR_W-1:0] ofs
   );
      return b.addr == ofs;
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [FIELD_W-1:0] v);
      return {{(DATA_W - FIELD_W){1'b0}}, v};
   endfunction

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // =========================================================
   // Status FIFO
   uoes_stat_fifo #(
      .DEPTH(STAT_FIFO_DEPTH)
   ) u_stat_fifo (
      .clk(clk),
      .reset(reset),
      .push_valid(rec_push),
      .push_ready(rec_push_ready),
      .push_rec(rec_in),
      .pop(fifo_pop),
      .head_valid(head_valid),
      .head_rec(head_rec)
   );

   // Token-done is simply a non-empty FIFO, so a record landing during the clear shows again
   assign fifo_pop = bus.wr && hit(bus, OFS_IRQ_FLAG) && bus.wdata[IRQ_TRN_BIT];

   // =========================================================
   // Error flag sources and summary
   always_comb begin
      err_set = err_event;
      err_set.crc5_or_eof = s.host_en ? eof_err_event : err_event.crc5_or_eof;
   end

   assign err_summary = |(s.err_flag & s.err_en);

   // =========================================================
   // Readback views
   always_comb begin
      stat_read = {head_rec.endpoint, head_rec.tx, head_rec.odd_bank, STAT_PAD};
      // Undefined while empty; head slot is shown as is
      if (!head_valid) begin
         stat_read = {head_rec.endpoint, head_rec.tx, head_rec.odd_bank, STAT_PAD};
      end
      ctl_read = '0;
      ctl_read[CTL_J_BIT] = s.j_s2;
      ctl_read[CTL_SE0_BIT] = s.se0_s2;
      ctl_read[CTL_PKT_BIT] = s.host_en ? token_in_progress : s.pkt_dis;
      ctl_read[CTL_RST_BIT] = s.bus_rst;
      ctl_read[CTL_HOST_BIT] = s.host_en;
      ctl_read[CTL_RESUME_BIT] = s.resume;
      ctl_read[CTL_PPB_BIT] = s.ppb_rst;
      ctl_read[CTL_EN_BIT] = s.mod_en;
      irq_read = '0;
      irq_read[IRQ_TRN_BIT] = head_valid;
      irq_read[IRQ_UERR_BIT] = err_summary;
   end

   // =========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.j_s1 = live_j_state_pin;
      next_s.j_s2 = s.j_s1;
      next_s.se0_s1 = live_se0_pin;
      next_s.se0_s2 = s.se0_s1;
      next_s.host_rst_pulse = 1'b0;
      next_s.ls_eop_pulse = 1'b0;
      next_s.sof_tick = 1'b0;

      // Register writes
      next_s.err_flag = w1c_update(s.err_flag, err_set,
         (bus.wr && hit(bus, OFS_ERR_FLAG)) ? bus.wdata[FIELD_W-1:0] : '0);
      if (bus.wr && hit(bus, OFS_ERR_EN)) begin
         next_s.err_en = bus.wdata[FIELD_W-1:0];
      end
      if (bus.wr && hit(bus, OFS_IRQ_EN)) begin
         next_s.token_done_ie = bus.wdata[IRQ_TRN_BIT];
         next_s.usb_error_summary_en = bus.wdata[IRQ_UERR_BIT];
      end
      if (bus.wr && hit(bus, OFS_CONTROL)) begin
         next_s.pkt_dis = bus.wdata[CTL_PKT_BIT];
         next_s.bus_rst = bus.wdata[CTL_RST_BIT];
         next_s.host_en = bus.wdata[CTL_HOST_BIT];
         next_s.resume = bus.wdata[CTL_RESUME_BIT];
         next_s.ppb_rst = bus.wdata[CTL_PPB_BIT];
         next_s.mod_en = bus.wdata[CTL_EN_BIT];
         next_s.host_rst_pulse = bus.wdata[CTL_HOST_BIT] != s.host_en;
         next_s.ls_eop_pulse = s.host_en && s.resume && !bus.wdata[CTL_RESUME_BIT];
      end
      // Writes to the status offset fall through untouched
      if (setup_token_rx && !s.host_en) begin
         next_s.pkt_dis = 1'b1;
      end

      // Start-of-frame timer, part of host control logic
      if (!(s.host_en && s.mod_en) || s.host_rst_pulse) begin
         next_s.sof_cnt = SOF_CYCLES - 1'b1;
      end else if (s.sof_cnt == '0) begin
         next_s.sof_cnt = SOF_CYCLES - 1'b1;
         next_s.sof_tick = 1'b1;
      end else begin
         next_s.sof_cnt = s.sof_cnt - 1'b1;
      end

      // Read data, valid the cycle after the strobe
      next_s.rdata = '0;
      if (bus.rd) begin
         unique case (bus.addr)
            OFS_ERR_FLAG: next_s.rdata = widen(s.err_flag);
            OFS_ERR_EN: next_s.rdata = widen(s.err_en);
            OFS_STATUS: next_s.rdata = widen(stat_read);
            OFS_CONTROL: next_s.rdata = widen(ctl_read);
            OFS_IRQ_FLAG: next_s.rdata = widen(irq_read);
            OFS_IRQ_EN: begin
               next_s.rdata[IRQ_TRN_BIT] = s.token_done_ie;
               next_s.rdata[IRQ_UERR_BIT] = s.usb_error_summary_en;
            end
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.err_en <= ERR_EN_RESET;
         s.sof_cnt <= SOF_CYCLES - 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // =========================================================
   // Outputs
   assign rdata = s.rdata;
   assign usb_main_irq_request = (err_summary && s.usb_error_summary_en) ||
      (head_valid && s.token_done_ie);
   assign packet_processing_disable = s.pkt_dis && !s.host_en;
   assign bus_reset_drive = s.bus_rst && s.host_en;
   assign host_capability_en = s.host_en;
   assign host_ctl_reset = s.host_rst_pulse;
   // Duration is up to software, the block only drives while the bit is set
   assign resume_drive = s.resume;
   assign low_speed_eop = s.ls_eop_pulse;
   assign pingpong_pointer_clear = s.ppb_rst;
   assign module_enable = s.mod_en && !s.host_en;
   assign frame_start_token_en = s.mod_en && s.host_en;
   assign frame_start_tick = s.sof_tick;

endmodule // uoes_top

/* verification/tb_uoes_top.sv */
// Purpose: Self-checking bench for the USB error, status and control block
// Assumes: Frame timer shortened to 20 cycles
// Notes: Far-side events come from uoes_far_end
`timescale 1ns/1ps
module tb_uoes_top;
   import uoes_pkg::*;
   typedef struct packed {
      logic [7:0] en, ie, ev;
      logic eof, host, irq;
      logic [7:0] flags;
   } uoes_row_t;
   logic clk, reset, wr, rd, rec_push, rec_push_ready, setup_token_rx, token_in_progress;
   logic live_j_state_pin, live_se0_pin, usb_main_irq_request, packet_processing_disable;
   logic bus_reset_drive, host_capability_en, host_ctl_reset, resume_drive, low_speed_eop;
   logic pingpong_pointer_clear, module_enable, frame_start_token_en, frame_start_tick;
   logic eof_err_event;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   uoes_err_t err_event;
   uoes_rec_t rec_in;
   int failures = 0;
   int n_compared = 0;
   int ticks;
   uoes_rec_t recs [5] = '{6'h00, 6'h3f, 6'h16, 6'h29, 6'h3c};
   uoes_row_t rows [8] = '{
      '{8'h80, 8'h02, 8'h80, 1'b0, 1'b0, 1'b1, 8'h80}, '{8'h7f, 8'h02, 8'h80, 1'b0, 1'b0, 1'b0, 8'h80},
      '{8'hff, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0, 8'h01}, '{8'h02, 8'h02, 8'h02, 1'b0, 1'b0, 1'b1, 8'h02},
      '{8'h02, 8'h02, 8'h00, 1'b1, 1'b1, 1'b1, 8'h02}, '{8'h02, 8'h02, 8'h02, 1'b0, 1'b1, 1'b0, 8'h00},
      '{8'h14, 8'h02, 8'h24, 1'b0, 1'b0, 1'b1, 8'h24}, '{8'h6b, 8'h02, 8'h94, 1'b0, 1'b0, 1'b0, 8'h94}};
   uoes_top #(.SOF_CYCLES(16'h0014)) uoes_top_inst (.*);
   uoes_far_end uoes_far_end_inst (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========================================
   // Watchdog, far above the few hundred cycles needed
   initial begin
      #200000;
      failures++;
      end_of_test();
   end
   initial begin
      {reset, wr, rd, addr, wdata} = '0;
      reset = 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(OFS_CONTROL, {28'h0, rows[i].host, 3'h0});
         wr_reg(OFS_ERR_EN, 32'(rows[i].en));
         wr_reg(OFS_IRQ_EN, 32'(rows[i].ie));
         rd_reg(OFS_ERR_EN, d);
         chk("err_en", 32'(rows[i].en), d);
         uoes_far_end_inst.fault(rows[i].ev, rows[i].eof);
         rd_reg(OFS_ERR_FLAG, d);
         chk("flags", 32'(rows[i].flags), d);
         chk("irq", 32'(rows[i].irq), 32'(usb_main_irq_request));
         wr_reg(OFS_ERR_FLAG, 32'hff);
         rd_reg(OFS_ERR_FLAG, d);
         chk("flags_clr", 32'h0, d);
      end
      // ==========================================
      // Status FIFO: fill past full, then drain in order
      for (int k = 0; k < 5; k++) begin
         uoes_far_end_inst.xfer(recs[k]);
      end
      chk("ready", 32'h0, 32'(rec_push_ready));
      wr_reg(OFS_IRQ_EN, 32'h8);
      chk("trn_irq", 32'h1, 32'(usb_main_irq_request));
      for (int k = 0; k < 4; k++) begin
         rd_reg(OFS_IRQ_FLAG, d);
         chk("done", 32'h1, 32'(d[IRQ_TRN_BIT]));
         wr_reg(OFS_STATUS, 32'hff);
         rd_reg(OFS_STATUS, d);
         chk("status", 32'({recs[k], 2'b00}), d);
         wr_reg(OFS_IRQ_FLAG, 32'h8);
      end
      rd_reg(OFS_IRQ_FLAG, d);
      chk("empty", 32'h0, 32'(d[IRQ_TRN_BIT]));
      chk("trn_irq_off", 32'h0, 32'(usb_main_irq_request));
      // ==========================================
      // Control register
      for (int k = 1; k < 4; k++) begin
         uoes_far_end_inst.line(k == 1, k == 2);
         repeat (3) @(posedge clk);
         rd_reg(OFS_CONTROL, d);
         chk("line", 32'({k == 1, k == 2}), 32'(d[7:6]));
      end
      uoes_far_end_inst.setup();
      rd_reg(OFS_CONTROL, d);
      chk("pkt", 32'h1, 32'({d[CTL_PKT_BIT], packet_processing_disable} == 2'b11));
      wr_reg(OFS_CONTROL, 32'h8);
      chk("host_rst", 32'h1, 32'(host_ctl_reset));
      fork
         uoes_far_end_inst.token(6);
         begin
            repeat (2) @(posedge clk);
            rd_reg(OFS_CONTROL, d);
         end
      join
      chk("busy", 32'h1, 32'(d[CTL_PKT_BIT]));
      wait (!token_in_progress);
      rd_reg(OFS_CONTROL, d);
      chk("idle", 32'h8, d);
      wr_reg(OFS_CONTROL, 32'h18);
      chk("bus_rst", 32'h1, 32'(bus_reset_drive));
      // Resume held only briefly; the real hold time is up to software
      wr_reg(OFS_CONTROL, 32'h0c);
      chk("bus_rst_end", 32'h1, 32'({bus_reset_drive, resume_drive} == 2'b01));
      wr_reg(OFS_CONTROL, 32'h08);
      chk("eop", 32'h1, 32'(low_speed_eop));
      wr_reg(OFS_CONTROL, 32'h09);
      chk("sof_en", 32'h1, 32'(frame_start_token_en));
      repeat (25) @(posedge clk);
      ticks = 0;
      repeat (100) begin
         @(negedge clk);
         ticks += int'(frame_start_tick);
      end
      chk("ticks", 32'h5, 32'(ticks));
      wr_reg(OFS_CONTROL, 32'h3);
      chk("mode", 32'h5, {29'h0, pingpong_pointer_clear, host_capability_en, module_enable});
      wr_reg(OFS_ERR_EN, 32'hffff_ffff);
      rd_reg(OFS_ERR_EN, d);
      chk("err_en_w", 32'hff, d);
      rd_reg(8'h20, d);
      chk("unmapped", 32'h0, d);
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd_reg(OFS_ERR_EN, d);
      chk("err_en_rst", 32'h0, d);
      chk("rst_out", 32'h1, 32'({rec_push_ready, pingpong_pointer_clear, module_enable} == 3'b100));
      end_of_test();
   end
endmodule // tb_uoes_top

/* verification/uoes_far_end.sv */
// Purpose: Cable-side events and line levels seen by the block
// Assumes: All events land on clk
// Notes: Record lines show the inverse once released
`timescale 1ns/1ps
module uoes_far_end
   import uoes_pkg::*;
(
   input wire logic clk,
   output uoes_err_t err_event,
   output logic eof_err_event,
   output logic rec_push,
   output uoes_rec_t rec_in,
   output logic setup_token_rx,
   output logic token_in_progress,
   output logic live_j_state_pin,
   output logic live_se0_pin
);
   initial begin
      {err_event, eof_err_event, rec_push, rec_in} = '0;
      {setup_token_rx, token_in_progress, live_j_state_pin, live_se0_pin} = '0;
   end
   task automatic line(input logic j, input logic se0);
      @(posedge clk);
      live_j_state_pin <= j;
      live_se0_pin <= se0;
   endtask
   task automatic fault(input logic [7:0] e, input logic eof);
      @(posedge clk);
      err_event <= uoes_err_t'(e);
      eof_err_event <= eof;
      @(posedge clk);
      err_event <= '0;
      eof_err_event <= 1'b0;
   endtask
   task automatic xfer(input uoes_rec_t r);
      @(posedge clk);
      rec_in <= r;
      rec_push <= 1'b1;
      @(posedge clk);
      rec_push <= 1'b0;
      rec_in <= ~r;
   endtask
   task automatic setup();
      @(posedge clk);
      setup_token_rx <= 1'b1;
      @(posedge clk);
      setup_token_rx <= 1'b0;
   endtask
   task automatic token(input int n);
      @(posedge clk);
      token_in_progress <= 1'b1;
      repeat (n) @(posedge clk);
      token_in_progress <= 1'b0;
   endtask
endmodule // uoes_far_end

/* verification/uoes_top_properties.sv */
// Purpose: Timing checks on the USB error, status and control block
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only top-level ports
`timescale 1ns/1ps
module uoes_top_properties
   import uoes_pkg::*;
#(
   parameter logic [SOF_CNT_W-1:0] SOF_CYCLES = 16'h0014
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic setup_token_rx,
   input wire logic token_in_progress,
   input wire logic packet_processing_disable,
   input wire logic bus_reset_drive,
   input wire logic host_capability_en,
   input wire logic host_ctl_reset,
   input wire logic resume_drive,
   input wire logic low_speed_eop,
   input wire logic module_enable,
   input wire logic frame_start_token_en,
   input wire logic frame_start_tick
);
   // ==========================================
   // Tick spacing, restarted whenever the timer may restart
   logic [SOF_CNT_W-1:0] gap;
   logic seen;
   always_ff @(posedge clk) begin
      if (reset || !frame_start_token_en || host_ctl_reset) begin
         gap <= '0;
         seen <= 1'b0;
      end else if (frame_start_tick) begin
         gap <= '0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1'b1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================
   // Assertions
   chk_high_zero: assert property (rd |=> rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_stat_pad: assert property (rd && addr == OFS_STATUS |=> rdata[1:0] == STAT_PAD)
      else $error("status low bits not zero");
   chk_busy_view: assert property (rd && addr == OFS_CONTROL && host_capability_en |=>
      rdata[CTL_PKT_BIT] == $past(token_in_progress)) else $error("busy view wrong");
   chk_setup_sets: assert property (setup_token_rx && !host_capability_en && !wr |=>
      packet_processing_disable) else $error("setup did not disable packets");
   chk_pkt_mode: assert property (wr && addr == OFS_CONTROL && !setup_token_rx |=>
      packet_processing_disable == ($past(wdata[CTL_PKT_BIT]) && !$past(wdata[CTL_HOST_BIT])))
      else $error("packet disable not as written");
   chk_rst_mode: assert property (wr && addr == OFS_CONTROL |=>
      bus_reset_drive == ($past(wdata[CTL_RST_BIT]) && $past(wdata[CTL_HOST_BIT])))
      else $error("bus reset not as written");
   chk_host_toggle: assert property ($changed(host_capability_en) |-> ##[0:1] host_ctl_reset)
      else $error("host toggle without host reset");
   chk_eop_end: assert property ($fell(resume_drive) && host_capability_en |->
      ##[0:1] low_speed_eop) else $error("no end-of-packet after resume");
   chk_en_split: assert property (module_enable |-> !host_capability_en && !frame_start_token_en)
      else $error("enable meaning wrong");
   chk_sof_gap: assert property (frame_start_tick && seen |-> gap == SOF_CYCLES - 1'b1)
      else $error("frame tick spacing wrong");
   cover property (frame_start_tick && seen);
   cover property (low_speed_eop);
   cover property (setup_token_rx && !host_capability_en);
endmodule // uoes_top_properties

bind uoes_top uoes_top_properties #(.SOF_CYCLES(SOF_CYCLES)) uoes_top_properties_inst (
   .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .setup_token_rx(setup_token_rx), .token_in_progress(token_in_progress),
   .packet_processing_disable(packet_processing_disable), .bus_reset_drive(bus_reset_drive),
   .host_capability_en(host_capability_en), .host_ctl_reset(host_ctl_reset),
   .resume_drive(resume_drive), .low_speed_eop(low_speed_eop), .module_enable(module_enable),
   .frame_start_token_en(frame_start_token_en), .frame_start_tick(frame_start_tick)
);
